// file: common/fanfm_pkg.sv
// Constants and types shared by the fan fault mask and configuration block
package fanfm_pkg;
  localparam int        NUM_FANS      = 4;
  localparam int        DRV_W         = 9;
  localparam int        TCH_W         = 11;
  localparam int        ADDR_W        = 8;
  localparam int        DATA_W        = 8;
  // Register map
  localparam logic [7:0] OFF_MASK     = 8'h01;
  localparam logic [7:0] OFF_CFG_BASE = 8'h02;
  localparam logic [7:0] OFF_CFG_LAST = 8'h05;
  // Fault status and mask register layout
  localparam int        STATUS_LSB    = 4;
  localparam logic [3:0] MASK_RESET   = 4'h0;
  localparam logic [3:0] STATUS_RESET = 4'h0;
  // Configuration register layout
  localparam int        CFG_MODE_BIT  = 7;
  localparam int        CFG_SPIN_HI   = 6;
  localparam int        CFG_SPIN_LO   = 5;
  localparam logic [7:0] CFG_WR_MASK  = 8'hEE;
  localparam logic [7:0] CFG_RESET    = 8'h00;
  localparam logic [7:0] RD_UNMAPPED  = 8'h00;
  // Drive levels
  localparam logic [8:0] DRV_FULL     = 9'h1FF;
  localparam logic [8:0] DRV_ZERO     = 9'h000;
  localparam logic [8:0] DRV_STEP     = 9'h001;
  // Spin-up codes and their limits in milliseconds
  localparam logic [1:0] SPIN_OFF     = 2'h0;
  localparam logic [1:0] SPIN_HALF    = 2'h1;
  localparam logic [1:0] SPIN_ONE     = 2'h2;
  localparam logic [1:0] SPIN_TWO     = 2'h3;
  localparam logic [11:0] SPIN_HALF_MS = 12'h1F4;
  localparam logic [11:0] SPIN_ONE_MS  = 12'h3E8;
  localparam logic [11:0] SPIN_TWO_MS  = 12'h7D0;
  localparam logic [1:0] SPIN_PULSES   = 2'h2;
  // Millisecond tick derived from the clock
  localparam int        CLK_PERIOD_NS = 10;
  localparam int        MS_NS         = 1000000;
  localparam int        MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    FANFM_IDLE = 2'h0,
    FANFM_SPIN = 2'h1,
    FANFM_RUN  = 2'h3
  } fanfm_state_type;
endpackage

// file: common/fanfm_chan_if.sv
// Signals between the register block and one fan drive channel
`timescale 1ns/1ps
interface fanfm_chan_if;
  import fanfm_pkg::*;
  logic              mode_rpm;
  logic [1:0]        spin_code;
  logic              start;
  logic [DRV_W-1:0]  target_drive;
  logic [TCH_W-1:0]  target_tach;
  logic [TCH_W-1:0]  tach_count;
  logic              tach_pulse;
  logic              locked;
  logic              ms_tick;
  logic [DRV_W-1:0]  drive;
  logic              spinning;
  modport ctl  (output mode_rpm, spin_code, start, target_drive, target_tach, tach_count,
                tach_pulse, locked, ms_tick, input drive, spinning);
  modport chan (input mode_rpm, spin_code, start, target_drive, target_tach, tach_count,
                tach_pulse, locked, ms_tick, output drive, spinning);
endinterface

// file: hdl/fanfm_channel.sv
// One fan drive channel: spin-up sequencer, DAC follow and RPM regulation
`timescale 1ns/1ps
module fanfm_channel
  import fanfm_pkg::*;
(
  // Clock and reset
  input wire logic   clock,
  input wire logic   rst,
  // Channel link
  fanfm_chan_if.chan ch
);
  typedef struct packed {
    fanfm_state_type state;
    logic [DRV_W-1:0] drive;
    logic [11:0]      ms_cnt;
    logic [1:0]       pulses;
    logic             locked_prev;
    logic             spin;
  } fanfm_chan_type;

  fanfm_chan_type q;
  fanfm_chan_type n;
  logic [11:0]    limit_ms;
  logic           unlock;
  logic           spin_done;

  always_comb begin
    case (ch.spin_code)
      SPIN_HALF: limit_ms = SPIN_HALF_MS;
      SPIN_ONE:  limit_ms = SPIN_ONE_MS;
      default:   limit_ms = SPIN_TWO_MS;
    endcase
  end

  assign unlock    = q.locked_prev && !ch.locked;
  assign spin_done = (ch.tach_pulse && (q.pulses + 2'h1 == SPIN_PULSES)) || unlock
                     || (q.ms_cnt >= limit_ms);

  always_comb begin
    n = q;
    n.locked_prev = ch.locked;
    case (q.state)
      FANFM_SPIN: begin
        if (ch.tach_pulse) begin
          n.pulses = q.pulses + 2'h1;
        end
        if (ch.ms_tick) begin
          n.ms_cnt = q.ms_cnt + 12'h001;
        end
        if (spin_done) begin
          n.state = FANFM_RUN;
          n.drive = ch.target_drive;
        end
      end
      FANFM_IDLE, FANFM_RUN: begin
        if (ch.start && ch.spin_code != SPIN_OFF) begin
          n.state  = FANFM_SPIN;
          n.drive  = DRV_FULL;
          n.ms_cnt = 12'h000;
          n.pulses = 2'h0;
        end else if (ch.start || q.state == FANFM_RUN) begin
          n.state = FANFM_RUN;
          if (!ch.mode_rpm) begin
            n.drive = ch.target_drive;
          end else if (ch.ms_tick) begin
            // Regulation starts from whatever drive is present
            if (ch.tach_count > ch.target_tach && q.drive != DRV_FULL) begin
              n.drive = q.drive + DRV_STEP;
            end else if (ch.tach_count < ch.target_tach && q.drive != DRV_ZERO) begin
              n.drive = q.drive - DRV_STEP;
            end
          end
        end
      end
      default: n.state = FANFM_IDLE;
    endcase
    // Kept as its own flop so the spinning pin carries no decode logic
    n.spin = (n.state == FANFM_SPIN);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= '{state: FANFM_IDLE, drive: DRV_ZERO, ms_cnt: 12'h000, pulses: 2'h0,
             locked_prev: 1'b0, spin: 1'b0};
    end else begin
      q <= n;
    end
  end

  assign ch.drive    = q.drive;
  assign ch.spinning = q.spin;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_spin_full;
    q.state == FANFM_SPIN |-> q.drive == DRV_FULL;
  endproperty
  a_spin_full: assert property (p_spin_full) else $error("drive not full in spin-up");

  property p_spin_pulses;
    (q.state == FANFM_SPIN && q.pulses == 2'h1 && ch.tach_pulse) |=> q.state == FANFM_RUN;
  endproperty
  a_spin_pulses: assert property (p_spin_pulses) else $error("spin-up ignored 2nd pulse");

  property p_spin_end;
    (q.state == FANFM_SPIN && spin_done) |=> (q.state == FANFM_RUN
      && q.drive == $past(ch.target_drive));
  endproperty
  a_spin_end: assert property (p_spin_end) else $error("spin-up end drive wrong");

  property p_spin_bound;
    q.state == FANFM_SPIN |-> q.ms_cnt <= SPIN_TWO_MS;
  endproperty
  a_spin_bound: assert property (p_spin_bound) else $error("spin-up ran past limit");

  property p_spin_off;
    (q.state != FANFM_SPIN && ch.start && ch.spin_code == SPIN_OFF) |=> q.state == FANFM_RUN;
  endproperty
  a_spin_off: assert property (p_spin_off) else $error("spin-up taken while off");

  property p_spin_two;
    (q.state == FANFM_SPIN && ch.spin_code == SPIN_TWO && q.ms_cnt < SPIN_ONE_MS
      && !ch.tach_pulse && !unlock) |=> q.state == FANFM_SPIN;
  endproperty
  a_spin_two: assert property (p_spin_two) else $error("long spin-up ended early");

  property p_dac_follow;
    (q.state == FANFM_RUN && !ch.mode_rpm && !ch.start) |=> q.drive == $past(ch.target_drive);
  endproperty
  a_dac_follow: assert property (p_dac_follow) else $error("DAC drive not followed");

  property p_rpm_up;
    (q.state == FANFM_RUN && ch.mode_rpm && !ch.start && ch.ms_tick
      && ch.tach_count > ch.target_tach && q.drive != DRV_FULL)
      |=> q.drive == $past(q.drive) + DRV_STEP;
  endproperty
  a_rpm_up: assert property (p_rpm_up) else $error("slow fan drive not raised");

  property p_rpm_hold;
    (q.state == FANFM_RUN && ch.mode_rpm && !ch.start && !ch.ms_tick)
      |=> q.drive == $past(q.drive);
  endproperty
  a_rpm_hold: assert property (p_rpm_hold) else $error("drive moved off rate tick");

  c_spin_timeout: cover property (q.state == FANFM_SPIN && q.ms_cnt >= limit_ms);
  c_spin_pulses:  cover property (q.state == FANFM_SPIN && q.pulses == 2'h1 && ch.tach_pulse);
  c_rpm_step:     cover property (q.state == FANFM_RUN && ch.mode_rpm && ch.ms_tick);
endmodule // fanfm_channel

// file: hdl/fanfm_top.sv
// Fan fault status, fault mask and per-fan configuration registers
`timescale 1ns/1ps
module fanfm_top
  import fanfm_pkg::*;
#(
  parameter int MS_TICK_CYCLES = MS_CYCLES
) (
  // Clock and reset
  input  wire logic                           clock,
  input  wire logic                           rst,
  // Register port
  input  wire logic [ADDR_W-1:0]              reg_addr,
  input  wire logic [DATA_W-1:0]              reg_wdata,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  output logic      [DATA_W-1:0]              reg_rdata,
  // Strap
  input  wire logic [1:0]                     spin_strap,
  // Per-fan inputs
  input  wire logic [NUM_FANS-1:0]            fault_in,
  input  wire logic [NUM_FANS-1:0]            target_load,
  input  wire logic [NUM_FANS-1:0][DRV_W-1:0] target_drive,
  input  wire logic [NUM_FANS-1:0][TCH_W-1:0] target_tach,
  input  wire logic [NUM_FANS-1:0][TCH_W-1:0] tach_count,
  input  wire logic [NUM_FANS-1:0]            tach_pulse,
  input  wire logic [NUM_FANS-1:0]            locked_rotor,
  // Outputs
  output logic      [NUM_FANS-1:0][DRV_W-1:0] drive_out,
  output logic      [NUM_FANS-1:0]            spinning,
  output logic                                fan_fail
);
  localparam int MS_W = $clog2(MS_TICK_CYCLES + 1);
  localparam logic [MS_W-1:0] MS_LAST = MS_W'(MS_TICK_CYCLES - 1);

  typedef struct packed {
    logic [NUM_FANS-1:0]             mask;
    logic [NUM_FANS-1:0]             status;
    logic [NUM_FANS-1:0][DATA_W-1:0] cfg;
    logic [DATA_W-1:0]               rdata;
    logic                            fan_fail;
    logic                            strap_done;
    logic [MS_W-1:0]                 ms_cnt;
    logic                            ms_tick;
  } fanfm_regs_type;

  fanfm_regs_type q;
  fanfm_regs_type n;
  logic           hit_mask;
  logic           hit_cfg;
  logic [1:0]     cfg_idx;
  logic [ADDR_W-1:0] cfg_off;

  assign hit_mask = (reg_addr == OFF_MASK);
  assign hit_cfg  = (reg_addr >= OFF_CFG_BASE) && (reg_addr <= OFF_CFG_LAST);
  assign cfg_off  = reg_addr - OFF_CFG_BASE;
  assign cfg_idx  = cfg_off[1:0];

  always_comb begin
    n = q;
    // Millisecond tick paces both the spin-up timer and the RPM step rate
    n.ms_tick = (q.ms_cnt == MS_LAST);
    n.ms_cnt  = n.ms_tick ? '0 : q.ms_cnt + MS_W'(1);

    // A read empties the status, but a fault in the same cycle still lands
    if (reg_rd && hit_mask) begin
      n.status = STATUS_RESET;
    end
    n.status = n.status | fault_in;

    // Only unmasked fans reach the shared output
    n.fan_fail = |((q.status | fault_in) & ~q.mask);

    if (reg_wr && hit_mask) begin
      n.mask = reg_wdata[NUM_FANS-1:0];
    end
    if (reg_wr && hit_cfg) begin
      n.cfg[cfg_idx] = reg_wdata & CFG_WR_MASK;
    end

    // Strap is sampled once, in the first cycle after reset release
    if (!q.strap_done) begin
      n.strap_done = 1'b1;
      for (int i = 0; i < NUM_FANS; i++) begin
        n.cfg[i] = CFG_RESET;
        n.cfg[i][CFG_SPIN_HI:CFG_SPIN_LO] = spin_strap;
      end
    end

    if (reg_rd) begin
      if (hit_mask) begin
        n.rdata = {q.status, q.mask};
      end else if (hit_cfg) begin
        n.rdata = q.cfg[cfg_idx];
      end else begin
        n.rdata = RD_UNMAPPED;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= '{mask: MASK_RESET, status: STATUS_RESET, cfg: '0, rdata: '0, fan_fail: 1'b0,
             strap_done: 1'b0, ms_cnt: '0, ms_tick: 1'b0};
    end else begin
      q <= n;
    end
  end

  fanfm_chan_if ch_if [NUM_FANS] ();

  for (genvar g = 0; g < NUM_FANS; g++) begin : g_fan
    assign ch_if[g].mode_rpm     = q.cfg[g][CFG_MODE_BIT];
    assign ch_if[g].spin_code    = q.cfg[g][CFG_SPIN_HI:CFG_SPIN_LO];
    assign ch_if[g].start        = target_load[g];
    assign ch_if[g].target_drive = target_drive[g];
    assign ch_if[g].target_tach  = target_tach[g];
    assign ch_if[g].tach_count   = tach_count[g];
    assign ch_if[g].tach_pulse   = tach_pulse[g];
    assign ch_if[g].locked       = locked_rotor[g];
    assign ch_if[g].ms_tick      = q.ms_tick;
    assign drive_out[g]          = ch_if[g].drive;
    assign spinning[g]           = ch_if[g].spinning;

    fanfm_channel u_chan (
      .clock (clock),
      .rst   (rst),
      .ch    (ch_if[g])
    );
  end

  assign reg_rdata = q.rdata;
  assign fan_fail  = q.fan_fail;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_status_set;
    (fault_in != '0) |=> ((q.status & $past(fault_in)) == $past(fault_in));
  endproperty
  a_status_set: assert property (p_status_set) else $error("fault not latched");

  property p_status_hold;
    (q.status != '0 && !(reg_rd && hit_mask)) |=> ((q.status & $past(q.status))
      == $past(q.status));
  endproperty
  a_status_hold: assert property (p_status_hold) else $error("status lost without read");

  property p_read_clear;
    (reg_rd && hit_mask && fault_in == '0) |=> q.status == STATUS_RESET;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("status not cleared by read");

  property p_masked_quiet;
    (q.mask == '1) [*2] |-> !fan_fail;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("masked fault raised fail");

  property p_unmasked_fail;
    ((fault_in & ~q.mask) != '0) |=> fan_fail;
  endproperty
  a_unmasked_fail: assert property (p_unmasked_fail) else $error("unmasked fault missed");

  property p_strap_load;
    !q.strap_done |=> (q.cfg[0] == {1'b0, $past(spin_strap), 5'h00}
      && q.cfg[3] == {1'b0, $past(spin_strap), 5'h00});
  endproperty
  a_strap_load: assert property (p_strap_load) else $error("strap not loaded");

  property p_cfg_write;
    (q.strap_done && reg_wr && hit_cfg) |=> q.cfg[$past(cfg_idx)]
      == ($past(reg_wdata) & CFG_WR_MASK);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

  property p_mask_read;
    (reg_rd && hit_mask) |=> reg_rdata == {$past(q.status), $past(q.mask)};
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask register readback wrong");

  property p_mask_write;
    (reg_wr && hit_mask) |=> q.mask == $past(reg_wdata[NUM_FANS-1:0]);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write lost");

  property p_status_ro;
    (reg_wr && hit_mask && fault_in == '0) |=> q.status == $past(q.status);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status changed by write");

  property p_fail_latched;
    ((q.status & ~q.mask) != '0) |=> fan_fail;
  endproperty
  a_fail_latched: assert property (p_fail_latched) else $error("fault not on fail");

  property p_fail_quiet;
    (q.status == '0 && fault_in == '0) |=> !fan_fail;
  endproperty
  a_fail_quiet: assert property (p_fail_quiet) else $error("fail with no fault");

  property p_cfg_read;
    (reg_rd && hit_cfg) |=> reg_rdata == $past(q.cfg[cfg_idx]);
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("config readback wrong");

  property p_unmapped_read;
    (reg_rd && !hit_mask && !hit_cfg) |=> reg_rdata == RD_UNMAPPED;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("bad unmapped read");

  property p_rdata_stand;
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_rdata_stand: assert property (p_rdata_stand) else $error("read data moved");

  c_fan_fail:  cover property (fan_fail);
  c_read_clr:  cover property (reg_rd && hit_mask && q.status != '0);
endmodule // fanfm_top

// file: tb/fanfm_host_model.sv
// Register host model that issues single-cycle read and write strobes
`timescale 1ns/1ps
module fanfm_host_model
  import fanfm_pkg::*;
(
  // Clock
  input  wire logic              clock,
  // Register port
  output logic      [ADDR_W-1:0] reg_addr,
  output logic      [DATA_W-1:0] reg_wdata,
  output logic                   reg_wr,
  output logic                   reg_rd,
  input  wire logic [DATA_W-1:0] reg_rdata
);
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // Idle write data is inverted so a stale value can never pass as fresh
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock) #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge clock) #1;
    reg_wr    = 1'b0;
    reg_wdata = ~d;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock) #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge clock) #1;
    reg_rd   = 1'b0;
    d        = reg_rdata;
  endtask
endmodule // fanfm_host_model

// file: tb/test_fan_fault_mask_and_config.sv
// Self-checking testbench for the fan fault mask and configuration block
`timescale 1ns/1ps
module test_fan_fault_mask_and_config;
  import fanfm_pkg::*;
  localparam int TICK = 10;
  logic                           clock, rst;
  logic [ADDR_W-1:0]              reg_addr;
  logic [DATA_W-1:0]              reg_wdata, reg_rdata, d;
  logic                           reg_wr, reg_rd;
  logic [1:0]                     spin_strap;
  logic [NUM_FANS-1:0]            fault_in, target_load, tach_pulse, locked_rotor, spinning;
  logic [NUM_FANS-1:0][DRV_W-1:0] target_drive, drive_out;
  logic [NUM_FANS-1:0][TCH_W-1:0] target_tach, tach_count;
  logic                           fan_fail;
  logic [DRV_W-1:0]               held;
  int                             bad_count = 0;
  int                             checked = 0;

  fanfm_top #(.MS_TICK_CYCLES(TICK)) uut (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .spin_strap(spin_strap), .fault_in(fault_in), .target_load(target_load),
    .target_drive(target_drive), .target_tach(target_tach), .tach_count(tach_count),
    .tach_pulse(tach_pulse), .locked_rotor(locked_rotor), .drive_out(drive_out),
    .spinning(spinning), .fan_fail(fan_fail));
  fanfm_host_model host (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic do_reset(input logic [1:0] strap);
    @(posedge clock) #1;
    spin_strap = strap;
    rst        = 1'b1;
    repeat (6) @(posedge clock);
    #1 rst = 1'b0;
    repeat (3) @(posedge clock);
  endtask

  task automatic load(input int f);
    @(posedge clock) #1;
    target_load[f] = 1'b1;
    @(posedge clock) #1;
    target_load[f] = 1'b0;
  endtask

  task automatic tach(input int f);
    @(posedge clock) #1;
    tach_pulse[f] = 1'b1;
    @(posedge clock) #1;
    tach_pulse[f] = 1'b0;
  endtask

  // Lets k edges pass and steps off the edge so outputs are settled
  task automatic wait_clk(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  task automatic test_reset();
    for (int s = 0; s < 3; s++) begin
      do_reset(s[1:0]);
      for (int f = 0; f < NUM_FANS; f++) begin
        host.reg_read(OFF_CFG_BASE + 8'(f), d);
        check("cfg_por", 16'(d), {8'h00, 1'b0, s[1:0], 5'h00});
      end
    end
    host.reg_read(OFF_MASK, d);
    check("mask_por", 16'(d), 16'h0000);
    host.reg_write(OFF_MASK, 8'hF5);
    host.reg_read(OFF_MASK, d);
    check("mask_rw", 16'(d), 16'h0005);
    host.reg_read(8'h06, d);
    check("unmapped", 16'(d), 16'h0000);
    host.reg_write(8'h03, 8'hFF);
    host.reg_read(8'h03, d);
    check("cfg_rw", 16'(d), 16'h00EE);
    host.reg_write(8'h03, 8'h20);
    $display("test_reset done");
  endtask

  task automatic test_faults();
    @(posedge clock) #1;
    fault_in = 4'h1;
    @(posedge clock) #1;
    fault_in = 4'h0;
    check("fail_set", 16'(fan_fail), 16'h0001);
    wait_clk(3);
    check("fail_held", 16'(fan_fail), 16'h0001);
    host.reg_read(OFF_MASK, d);
    check("status", 16'(d), 16'h0010);
    wait_clk(2);
    check("fail_clr", 16'(fan_fail), 16'h0000);
    host.reg_write(OFF_MASK, 8'h02);
    @(posedge clock) #1;
    fault_in = 4'h2;
    @(posedge clock) #1;
    fault_in = 4'h0;
    wait_clk(2);
    check("fail_masked", 16'(fan_fail), 16'h0000);
    host.reg_read(OFF_MASK, d);
    check("status_masked", 16'(d), 16'h0022);
    @(posedge clock) #1;
    fault_in = 4'h6;
    @(posedge clock) #1;
    fault_in = 4'h0;
    check("fail_other", 16'(fan_fail), 16'h0001);
    host.reg_read(OFF_MASK, d);
    check("status_both", 16'(d), 16'h0062);
    host.reg_write(OFF_MASK, 8'h00);
    $display("test_faults done");
  endtask

  task automatic test_spin_pulses();
    target_drive[0] = 9'h055;
    load(0);
    check("spin_full", 16'(drive_out[0]), 16'(DRV_FULL));
    check("spin_flag", 16'(spinning[0]), 16'h0001);
    tach(0);
    wait_clk(3);
    check("one_pulse", 16'(spinning[0]), 16'h0001);
    tach(0);
    wait_clk(2);
    check("spin_end", 16'(spinning[0]), 16'h0000);
    check("spin_drive", 16'(drive_out[0]), 16'h0055);
    $display("test_spin_pulses done");
  endtask

  task automatic test_spin_timeout();
    int lims[4] = '{0, 500, 1000, 2000};
    int n;
    for (int c = 0; c < 4; c++) begin
      host.reg_write(8'h03, {1'b0, c[1:0], 5'h00});
      target_drive[1] = 9'h0AA + 9'(c);
      load(1);
      n = 0;
      while (spinning[1] === 1'b1 && n < 30000) begin
        @(posedge clock) #1;
        n++;
      end
      check("spin_time", 16'(n >= lims[c] * TICK - 12 && n <= lims[c] * TICK + 12),
            16'h0001);
      @(posedge clock) #1;
      check("timeout_drive", 16'(drive_out[1]), 16'(9'h0AA + 9'(c)));
    end
    $display("test_spin_timeout done");
  endtask

  task automatic test_locked();
    host.reg_write(8'h04, 8'h60);
    locked_rotor[2] = 1'b1;
    target_drive[2] = 9'h033;
    load(2);
    wait_clk(20);
    check("locked_spin", 16'(spinning[2]), 16'h0001);
    locked_rotor[2] = 1'b0;
    wait_clk(3);
    check("locked_end", 16'(spinning[2]), 16'h0000);
    check("locked_drive", 16'(drive_out[2]), 16'h0033);
    $display("test_locked done");
  endtask

  task automatic test_dac_rpm();
    int n;
    host.reg_write(8'h05, 8'h00);
    target_drive[3] = 9'h040;
    load(3);
    wait_clk(2);
    check("dac_drive", 16'(drive_out[3]), 16'h0040);
    target_drive[3] = 9'h123;
    wait_clk(2);
    check("dac_follow", 16'(drive_out[3]), 16'h0123);
    target_drive[3] = 9'h040;
    tach_count[3]   = 11'h200;
    target_tach[3]  = 11'h100;
    wait_clk(2);
    host.reg_write(8'h05, 8'h80);
    load(3);
    n = 0;
    while (drive_out[3] === 9'h040 && n < 40) begin
      @(posedge clock) #1;
      n++;
    end
    check("rpm_first", 16'(drive_out[3]), 16'h0041);
    wait_clk(10 * TICK);
    check("rpm_rate", 16'(drive_out[3] >= 9'h04A && drive_out[3] <= 9'h04C), 16'h1);
    tach_count[3] = 11'h100;
    wait_clk(2 * TICK);
    held = drive_out[3];
    wait_clk(5 * TICK);
    check("rpm_hold", 16'(drive_out[3]), 16'(held));
    tach_count[3] = 11'h080;
    wait_clk(3 * TICK);
    check("rpm_down", 16'(drive_out[3] < held), 16'h0001);
    $display("test_dac_rpm done");
  endtask

  initial begin
    rst = 1'b1;
    spin_strap = 2'h1;
    fault_in = 4'h0;
    target_load = 4'h0;
    tach_pulse = 4'h0;
    locked_rotor = 4'h0;
    target_drive = '0;
    target_tach = '0;
    tach_count = '0;
    test_reset();
    do_reset(2'h1);
    test_faults();
    test_spin_pulses();
    test_spin_timeout();
    test_locked();
    test_dac_rpm();
    final_report();
  end

  // Longest path is the spin timeouts, about 36000 cycles; 60000 leaves margin
  initial begin
    #(60000 * 10);
    bad_count++;
    final_report();
  end
endmodule // test_fan_fault_mask_and_config
